/* File: design/ffa_consts.vh */
// constants for the fault flag aggregation block
`ifndef FFA_CONSTS_VH
`define FFA_CONSTS_VH
// ==========================================================
// register byte addresses
`define FFA_A_MAIN      8'h00
`define FFA_A_PWR_FLAG  8'h04
`define FFA_A_CLK_FLAG  8'h08
`define FFA_A_LOG_FLAG  8'h0c
`define FFA_A_PWR_EN    8'h10
`define FFA_A_CLK_EN    8'h14
`define FFA_A_LOG_EN    8'h18
`define FFA_A_PWR_MASK  8'h1c
`define FFA_A_CLK_MASK  8'h20
`define FFA_A_LOG_MASK  8'h24
`define FFA_A_PIN_CFG   8'h28
`define FFA_A_PIN_MASK  8'h2c
`define FFA_A_PWM_DIV   8'h30
`define FFA_A_IRQ_STAT  8'h34
`define FFA_A_IRQ_MASK  8'h38
`define FFA_A_PIN_STATE 8'h3c
// ==========================================================
// field positions
`define FFA_MAIN_LO     7
`define FFA_MAIN_HI     14
`define FFA_MB_POWER    5
`define FFA_MB_CLOCK    6
`define FFA_MB_LOGIC    7
`define FFA_CFG_DIR     0
`define FFA_CFG_SRC     1
`define FFA_CFG_FMT_ACT 2
`define FFA_CFG_FMT_INA 3
`define FFA_CFG_POL     4
// ==========================================================
// reset values
`define FFA_FLAG_RST    8'hff
`define FFA_EN_RST      8'hff
`define FFA_MASK_RST    8'h00
`define FFA_CFG_RST     5'h00
`define FFA_DIV_RST     16'h00f9
`define FFA_IRQM_RST    8'hff
`define FFA_ZERO32      32'h0000_0000
`endif

/* File: design/ffa_pwm.v */
// 50 percent duty square wave for the heartbeat format
module ffa_pwm (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire [15:0] i_half,
  output reg         o_wave
);
  reg [15:0] cnt_q;

  // ==========================================================
  // half period counter
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q  <= 16'h0000;
      o_wave <= 1'b0;
    end else if (cnt_q >= i_half) begin
      cnt_q  <= 16'h0000;
      o_wave <= ~o_wave;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
    end
  end
endmodule

/* File: design/ffa_top.v */
// fault flag aggregation with alarm pin and apb registers
//
// Contract
// RQ1 - detailed flag reads 0 once its monitor detects, 1 when nothing latched
// RQ2 - group summary goes 0 while any unmasked detailed flag of group is 0
// RQ3 - host clears all detailed flags before returning a summary to 1
// RQ4 - writing 1 restores summary only when whole detailed register reads 1
// RQ5 - masked detailed flag never pulls its group summary to 0
// RQ6 - summary mask does not stop the detailed flag going 0
// RQ7 - disabled monitor reports nothing in detailed or summary flag
// RQ8 - summary mask 1 blocks flag, 0 lets it count, with monitor enabled
// RQ9 - pin 2 is alarm output when direction is 1 and source is 0
// RQ10 - alarm active while any unmasked main flag 14..7 reads 0
// RQ11 - alarm goes inactive at once when all main flags read 1
// RQ12 - polarity 0 makes alarm active low, 1 active high
// RQ13 - format 0 gives static levels for active and inactive state
// RQ14 - format 1 gives a 50 percent pwm heartbeat for that state
// RQ15 - each main flag has a pin mask bit that keeps it off the pin
// RQ16 - writing 0 to any flag leaves it; only detection drives 0
`include "ffa_consts.vh"
module ffa_top (
  input  wire        I_CLK,
  input  wire        I_RST,
  input  wire        I_PSEL,
  input  wire        I_PENABLE,
  input  wire        I_PWRITE,
  input  wire [7:0]  I_PADDR,
  input  wire [31:0] I_PWDATA,
  output reg  [31:0] O_PRDATA,
  output reg         O_PREADY,
  output reg         O_PSLVERR,
  input  wire [7:0]  I_POWER_DET,
  input  wire [7:0]  I_CLOCK_DET,
  input  wire [7:0]  I_LOGIC_DET,
  input  wire [4:0]  I_OTHER_DET,
  input  wire        I_GP_DATA,
  output reg         O_PIN2_O,
  output reg         O_PIN2_OE,
  output reg         O_IRQ
);

  // ==========================================================
  // state
  reg  [7:0]  pwr_flag_q;
  reg  [7:0]  clk_flag_q;
  reg  [7:0]  log_flag_q;
  reg  [7:0]  pwr_en_q;
  reg  [7:0]  clk_en_q;
  reg  [7:0]  log_en_q;
  reg  [7:0]  pwr_mask_q;
  reg  [7:0]  clk_mask_q;
  reg  [7:0]  log_mask_q;
  reg  [7:0]  main_q;
  reg  [4:0]  cfg_q;
  reg  [7:0]  pin_mask_q;
  reg  [15:0] div_q;
  reg  [7:0]  irq_stat_q;
  reg  [7:0]  irq_mask_q;
  reg         alarm_q;

  wire [7:0]  pwr_flag_d;
  wire [7:0]  clk_flag_d;
  wire [7:0]  log_flag_d;
  wire [7:0]  pwr_hit;
  wire [7:0]  clk_hit;
  wire [7:0]  log_hit;
  reg  [7:0]  main_d;
  wire [7:0]  irq_stat_d;
  wire        alarm_d;
  wire        heartbeat;
  reg         level_d;
  reg         oe_d;
  reg  [31:0] rdata_d;
  reg         err_d;

  // ==========================================================
  // apb decode
  wire        wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  wire [7:0]  wd = I_PWDATA[7:0];
  wire [7:0]  wmain = I_PWDATA[`FFA_MAIN_HI:`FFA_MAIN_LO];
  wire        wr_main = wr & (I_PADDR == `FFA_A_MAIN);
  wire        wr_pwr = wr & (I_PADDR == `FFA_A_PWR_FLAG);
  wire        wr_clk = wr & (I_PADDR == `FFA_A_CLK_FLAG);
  wire        wr_log = wr & (I_PADDR == `FFA_A_LOG_FLAG);
  wire        wr_irq = wr & (I_PADDR == `FFA_A_IRQ_STAT);

  // ==========================================================
  // detailed flags, one slice per bit
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_flag
      // disabled monitor holds flag at 1; detection beats a clear write
      assign pwr_flag_d[i] = ~pwr_en_q[i] |
        ((pwr_flag_q[i] | (wr_pwr & wd[i])) & ~I_POWER_DET[i]); // RQ1 RQ7 RQ16
      assign clk_flag_d[i] = ~clk_en_q[i] |
        ((clk_flag_q[i] | (wr_clk & wd[i])) & ~I_CLOCK_DET[i]); // RQ1 RQ7 RQ16
      assign log_flag_d[i] = ~log_en_q[i] |
        ((log_flag_q[i] | (wr_log & wd[i])) & ~I_LOGIC_DET[i]); // RQ1 RQ7 RQ16
      // summary contribution; mask does not touch the flag itself
      assign pwr_hit[i] = pwr_en_q[i] & ~pwr_flag_q[i] & ~pwr_mask_q[i]; // RQ5 RQ6 RQ8
      assign clk_hit[i] = clk_en_q[i] & ~clk_flag_q[i] & ~clk_mask_q[i]; // RQ5 RQ6 RQ8
      assign log_hit[i] = log_en_q[i] & ~log_flag_q[i] & ~log_mask_q[i]; // RQ5 RQ6 RQ8
    end
  endgenerate

  // ==========================================================
  // main status byte
  always @* begin
    // other faults: set to 0 by detection, write 1 restores
    main_d[4:0] = (main_q[4:0] | (wmain[4:0] & {5{wr_main}})) & ~I_OTHER_DET; // RQ16
    // summaries: restore only when the detailed register is all ones
    main_d[`FFA_MB_POWER] = ~(|pwr_hit) & (main_q[`FFA_MB_POWER] |
      (wr_main & wmain[`FFA_MB_POWER] & (&pwr_flag_q))); // RQ2 RQ4 RQ16
    main_d[`FFA_MB_CLOCK] = ~(|clk_hit) & (main_q[`FFA_MB_CLOCK] |
      (wr_main & wmain[`FFA_MB_CLOCK] & (&clk_flag_q))); // RQ2 RQ4 RQ16
    main_d[`FFA_MB_LOGIC] = ~(|log_hit) & (main_q[`FFA_MB_LOGIC] |
      (wr_main & wmain[`FFA_MB_LOGIC] & (&log_flag_q))); // RQ2 RQ4 RQ16
  end

  // ==========================================================
  // interrupt: sticky on a main flag falling, set wins over clear
  assign irq_stat_d = (irq_stat_q & ~(wd & {8{wr_irq}})) | (main_q & ~main_d);

  // ==========================================================
  // alarm pin
  assign alarm_d = |(~main_d & ~pin_mask_q); // RQ10 RQ11 RQ15

  always @* begin
    oe_d    = 1'b0;
    level_d = 1'b0;
    if (cfg_q[`FFA_CFG_DIR]) begin
      oe_d = 1'b1;
      if (cfg_q[`FFA_CFG_SRC]) begin
        level_d = I_GP_DATA;
      end else if (alarm_d) begin // RQ9
        if (cfg_q[`FFA_CFG_FMT_ACT]) begin
          level_d = heartbeat; // RQ14
        end else begin
          level_d = cfg_q[`FFA_CFG_POL]; // RQ12 RQ13
        end
      end else begin
        if (cfg_q[`FFA_CFG_FMT_INA]) begin
          level_d = heartbeat; // RQ14
        end else begin
          level_d = ~cfg_q[`FFA_CFG_POL]; // RQ12 RQ13
        end
      end
    end
  end

  ffa_pwm u_pwm (
    .i_clk  (I_CLK),
    .i_rst  (I_RST),
    .i_half (div_q),
    .o_wave (heartbeat)
  );

  // ==========================================================
  // read mux
  always @* begin
    rdata_d = `FFA_ZERO32;
    err_d   = 1'b0;
    case (I_PADDR)
      `FFA_A_MAIN:      rdata_d[`FFA_MAIN_HI:`FFA_MAIN_LO] = main_q;
      `FFA_A_PWR_FLAG:  rdata_d[7:0] = pwr_flag_q;
      `FFA_A_CLK_FLAG:  rdata_d[7:0] = clk_flag_q;
      `FFA_A_LOG_FLAG:  rdata_d[7:0] = log_flag_q;
      `FFA_A_PWR_EN:    rdata_d[7:0] = pwr_en_q;
      `FFA_A_CLK_EN:    rdata_d[7:0] = clk_en_q;
      `FFA_A_LOG_EN:    rdata_d[7:0] = log_en_q;
      `FFA_A_PWR_MASK:  rdata_d[7:0] = pwr_mask_q;
      `FFA_A_CLK_MASK:  rdata_d[7:0] = clk_mask_q;
      `FFA_A_LOG_MASK:  rdata_d[7:0] = log_mask_q;
      `FFA_A_PIN_CFG:   rdata_d[4:0] = cfg_q;
      `FFA_A_PIN_MASK:  rdata_d[7:0] = pin_mask_q;
      `FFA_A_PWM_DIV:   rdata_d[15:0] = div_q;
      `FFA_A_IRQ_STAT:  rdata_d[7:0] = irq_stat_q;
      `FFA_A_IRQ_MASK:  rdata_d[7:0] = irq_mask_q;
      `FFA_A_PIN_STATE: rdata_d[1:0] = {O_PIN2_O, alarm_q};
      default:          err_d = 1'b1;
    endcase
  end

  // ==========================================================
  // bus answer: one wait-free access phase after setup
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= `FFA_ZERO32;
    end else begin
      O_PREADY  <= I_PSEL & ~I_PENABLE;
      O_PSLVERR <= I_PSEL & ~I_PENABLE & err_d;
      if (I_PSEL & ~I_PENABLE & ~I_PWRITE) begin
        O_PRDATA <= rdata_d;
      end
    end
  end

  // ==========================================================
  // flags and status
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pwr_flag_q <= `FFA_FLAG_RST;
      clk_flag_q <= `FFA_FLAG_RST;
      log_flag_q <= `FFA_FLAG_RST;
      main_q     <= `FFA_FLAG_RST;
      irq_stat_q <= `FFA_MASK_RST;
      alarm_q    <= 1'b0;
      O_PIN2_O   <= 1'b0;
      O_PIN2_OE  <= 1'b0;
      O_IRQ      <= 1'b0;
    end else begin
      pwr_flag_q <= pwr_flag_d;
      clk_flag_q <= clk_flag_d;
      log_flag_q <= log_flag_d;
      main_q     <= main_d;
      irq_stat_q <= irq_stat_d;
      alarm_q    <= alarm_d; // RQ10 RQ11
      O_PIN2_O   <= level_d;
      O_PIN2_OE  <= oe_d; // RQ9
      O_IRQ      <= |(irq_stat_d & ~irq_mask_q);
    end
  end

  // ==========================================================
  // configuration registers
  always @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pwr_en_q   <= `FFA_EN_RST;
      clk_en_q   <= `FFA_EN_RST;
      log_en_q   <= `FFA_EN_RST;
      pwr_mask_q <= `FFA_MASK_RST;
      clk_mask_q <= `FFA_MASK_RST;
      log_mask_q <= `FFA_MASK_RST;
      cfg_q      <= `FFA_CFG_RST;
      pin_mask_q <= `FFA_MASK_RST;
      div_q      <= `FFA_DIV_RST;
      irq_mask_q <= `FFA_IRQM_RST;
    end else if (wr) begin
      case (I_PADDR)
        `FFA_A_PWR_EN:   pwr_en_q   <= wd;
        `FFA_A_CLK_EN:   clk_en_q   <= wd;
        `FFA_A_LOG_EN:   log_en_q   <= wd;
        `FFA_A_PWR_MASK: pwr_mask_q <= wd; // RQ8
        `FFA_A_CLK_MASK: clk_mask_q <= wd; // RQ8
        `FFA_A_LOG_MASK: log_mask_q <= wd; // RQ8
        `FFA_A_PIN_CFG:  cfg_q      <= I_PWDATA[4:0];
        `FFA_A_PIN_MASK: pin_mask_q <= wd; // RQ15
        `FFA_A_PWM_DIV:  div_q      <= I_PWDATA[15:0];
        `FFA_A_IRQ_MASK: irq_mask_q <= wd;
        default: begin
        end
      endcase
    end
  end

endmodule

/* File: test/ffa_checker.sv */
// port assertions for the fault flag block
module ffa_checker (
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [7:0]  I_POWER_DET,
  input wire logic [7:0]  I_CLOCK_DET,
  input wire logic [7:0]  I_LOGIC_DET,
  input wire logic [4:0]  I_OTHER_DET,
  input wire logic        O_PIN2_O,
  input wire logic        O_PIN2_OE,
  input wire logic        O_IRQ
);
  // ========
  // helpers and properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  logic wr;
  logic det;
  assign wr = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign det = |{I_POWER_DET, I_CLOCK_DET, I_LOGIC_DET, I_OTHER_DET};
  a_ready_setup: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
    else $error("no ready after setup");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_idle_quiet: assert property (!I_PSEL |=> !O_PREADY)
    else $error("ready without request");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  a_err_zero: assert property (O_PSLVERR && !I_PWRITE |-> O_PRDATA == 32'h0)
    else $error("refused read data not zero");
  a_oe_low_pin: assert property (!O_PIN2_OE |-> !O_PIN2_O)
    else $error("pin driven while disabled");
  a_oe_by_write: assert property ($changed(O_PIN2_OE) |->
    $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("enable moved without a write");
  a_irq_cause: assert property ($rose(O_IRQ) |->
    $past(det) || $past(det, 2) || $past(det, 3) || $past(wr) || $past(wr, 2))
    else $error("interrupt without detection");
endmodule
bind ffa_top ffa_checker chk_u (.*);

/* File: test/ffa_host.sv */
// host model: apb master for the fault flag block
module ffa_host (
  input  wire logic        i_clk,
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [7:0]       o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // bus transfer and ordered clear
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    // wait for the answer; only the bench watchdog ends a hang
    do begin
      @(posedge i_clk);
    end while (i_pready !== 1'b1);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    @(posedge i_clk);
  endtask
  // detailed flags first, then the summary
  task automatic clr(input logic [7:0] fa);
    logic [31:0] q;
    logic e;
    xfer(1'b1, fa, 32'hff, q, e);
    xfer(1'b1, 8'h00, 32'h7f80, q, e);
  endtask
endmodule

/* File: test/ffa_top_test.sv */
// self-checking bench for the fault flag block
module ffa_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // signals, rows and tasks
  typedef struct packed {logic [1:0] g; logic [2:0] b; logic m; logic [7:0] em;} ffa_row_t;
  ffa_row_t rows [6] = '{'{0, 3, 0, 8'hdf}, '{1, 0, 0, 8'hbf}, '{2, 7, 0, 8'h7f},
                         '{0, 5, 1, 8'hff}, '{1, 6, 1, 8'hff}, '{2, 1, 1, 8'hff}};
  logic        clk, rst, gp, psel, penable, pwrite, pready, pslverr, pin, oe, irq, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [7:0]  det [4];
  int          num_errors, compares, n;
  ffa_top dut_u (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_POWER_DET(det[0]), .I_CLOCK_DET(det[1]),
    .I_LOGIC_DET(det[2]), .I_OTHER_DET(det[3][4:0]), .I_GP_DATA(gp), .O_PIN2_O(pin),
    .O_PIN2_OE(oe), .O_IRQ(irq));
  ffa_host host_u (.i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
    .i_pslverr(pslverr));
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task automatic end_sim;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, d, q, err);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    host_u.xfer(1'b0, a, 32'h0, q, err);
    chk(q, x);
  endtask
  task automatic pulse(input logic [1:0] g, input logic [2:0] b);
    det[g][b] <= 1'b1;
    @(posedge clk);
    det[g][b] <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [7:0] ga(input logic [7:0] a, input logic [1:0] g);
    return a + {4'h0, g, 2'b00};
  endfunction
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20us;
    num_errors++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    gp = 1'b0;
    det = '{default: 8'h00};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h00, 32'h7f80);
    rd(8'h10, 32'hff);
    rd(8'h1c, 32'h0);
    rd(8'h30, 32'hf9);
    rd(8'h38, 32'hff);
    chk(oe, 0);
    wr(8'h28, 32'h1);
    wr(8'h38, 32'h0);
    foreach (rows[i]) begin
      wr(ga(8'h1c, rows[i].g), {31'h0, rows[i].m} << rows[i].b);
      pulse(rows[i].g, rows[i].b);
      rd(ga(8'h04, rows[i].g), {24'h0, ~(8'h1 << rows[i].b)});
      rd(8'h00, {17'h0, rows[i].em, 7'h0});
      chk(pin, &rows[i].em);
      chk(irq, ~&rows[i].em);
      host_u.clr(ga(8'h04, rows[i].g));
      wr(8'h34, 32'hff);
      wr(ga(8'h1c, rows[i].g), 32'h0);
      rd(8'h00, 32'h7f80);
      chk(pin, 1);
      chk(irq, 0);
      $display("row %0d done", i);
    end
    wr(8'h38, 32'h20);
    pulse(0, 0);
    chk(irq, 0);
    wr(8'h00, 32'h7f80);
    rd(8'h00, 32'h6f80);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'hfe);
    wr(8'h38, 32'h0);
    chk(irq, 1);
    host_u.clr(8'h04);
    rd(8'h00, 32'h7f80);
    wr(8'h34, 32'hff);
    chk(irq, 0);
    $display("restore order done");
    wr(8'h10, 32'hfb);
    pulse(0, 2);
    rd(8'h04, 32'hff);
    rd(8'h00, 32'h7f80);
    wr(8'h10, 32'hff);
    $display("disable done");
    wr(8'h2c, 32'h1);
    pulse(3, 0);
    rd(8'h00, 32'h7f00);
    chk(pin, 1);
    wr(8'h2c, 32'h0);
    chk(pin, 0);
    wr(8'h28, 32'h11);
    chk(pin, 1);
    rd(8'h3c, 32'h3);
    wr(8'h00, 32'h7f80);
    chk(pin, 0);
    wr(8'h34, 32'hff);
    $display("pin mask and polarity done");
    wr(8'h28, 32'h9);
    wr(8'h30, 32'h1);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += pin;
    end
    chk(n, 20);
    pulse(1, 1);
    n = 0;
    repeat (8) begin
      @(posedge clk);
      n += pin;
    end
    chk(n, 0);
    wr(8'h28, 32'h5);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      n += pin;
    end
    chk(n, 20);
    host_u.clr(8'h08);
    wr(8'h34, 32'hff);
    $display("heartbeat done");
    wr(8'h28, 32'h3);
    gp <= 1'b1;
    repeat (3) @(posedge clk);
    chk(pin, 1);
    gp <= 1'b0;
    repeat (3) @(posedge clk);
    chk(pin, 0);
    wr(8'h28, 32'h0);
    chk(oe, 0);
    host_u.xfer(1'b0, 8'h40, 32'h0, q, err);
    chk(q, 0);
    chk(err, 1);
    $display("source and unmapped done");
    end_sim();
  end
endmodule
